//--- tb.sv
// self-checking bench of the timer block through its register port and pins.
// assumes tmr_timers, its bound checker and tmr_pin_model.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, arst_n, reg_wr, reg_rd, ack0, ack1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic f0, f1, f2, fx, w0, w2, rxt, txt;
  logic [1:0] mon;
  tmr_pkg::tmr_pins_t pins;
  int n_fail, tests_run;
  assign mon = {w2, w0};
  tmr_timers DUT (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pins(pins),
    .timer0_vector_ack(ack0), .timer1_vector_ack(ack1), .timer0_overflow_flag(f0),
    .timer1_overflow_flag(f1), .timer2_overflow_flag(f2), .timer2_trigger_flag(fx),
    .timer0_wave_out(w0), .timer2_wave_out(w2), .serial_rx_baud_tick(rxt),
    .serial_tx_baud_tick(txt));
  tmr_pin_model u_pins (.clk(clk), .pins(pins), .rx_tick(rxt), .tx_tick(txt));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ====================
  // shared tasks
  task automatic end_sim();
    if (n_fail == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk($sformatf("reg %h", a), exp, reg_rdata);
  endtask
  task automatic wchg(input int b, input int lim, output int n);
    logic v0;
    v0 = mon[b];
    n = 0;
    while (mon[b] === v0)
    begin
      @(negedge clk);
      n++;
      if (n > lim)
      begin
        n_fail++;
        $display("[ERR] wave %0d exp toggle got none", b);
        end_sim();
      end
    end
  endtask
  // ====================
  // scenarios
  task automatic t_regs();
    logic [7:0] a [12];
    a = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'hc8, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hf8};
    foreach (a[i]) rchk(a[i], 8'h00);
    rchk(8'h90, 8'h00);
    wr(8'hf8, 8'hff);
    rchk(8'hf8, 8'h06);
    wr(8'hf8, 8'h00);
    wr(8'h8c, 8'h5a);
    rchk(8'h8c, 8'h5a);
  endtask
  task automatic t_t0();
    int n;
    wr(8'h8c, 8'hff);
    wr(8'h8a, 8'hff);
    wr(8'h89, 8'h02);
    wr(8'h88, 8'h10);
    @(negedge clk);
    wchg(0, 300, n);
    wchg(0, 300, n);
    chk("wave0 gap", 8'h80, n[7:0]);
    chk("flag0", 8'h01, {7'h0, f0});
    wr(8'h88, 8'h20);
    rchk(8'h8a, 8'hff);
    @(posedge clk);
    ack0 <= 1'b1;
    @(posedge clk);
    ack0 <= 1'b0;
    @(negedge clk);
    chk("flag0 ack", 8'h00, {7'h0, f0});
  endtask
  task automatic t_gate();
    u_pins.level(tmr_pkg::PIN_EXT_IRQ_ZERO_PIN, 1'b0);
    wr(8'h8a, 8'hfe);
    wr(8'h8c, 8'h00);
    wr(8'h89, 8'h09);
    wr(8'h88, 8'h10);
    cyc(20);
    rchk(8'h8a, 8'hfe);
    wr(8'h88, 8'h00);
    u_pins.level(tmr_pkg::PIN_EXT_IRQ_ZERO_PIN, 1'b1);
    cyc(4);
    wr(8'h88, 8'h10);
    cyc(38);
    wr(8'h88, 8'h00);
    rchk(8'h8a, 8'h12);
    rchk(8'h8c, 8'h01);
  endtask
  task automatic t_cnt();
    wr(8'h89, 8'h50);
    wr(8'h88, 8'h40);
    u_pins.pulse(tmr_pkg::PIN_T1, 5);
    cyc(3);
    rchk(8'h8b, 8'h05);
    wr(8'hf8, 8'h02);
    u_pins.pulse(tmr_pkg::PIN_T1, 3);
    u_pins.pulse(tmr_pkg::PIN_SLOW, 32);
    cyc(3);
    rchk(8'h8b, 8'h07);
    wr(8'hf8, 8'h00);
    wr(8'h89, 8'h00);
    wr(8'h8b, 8'hfe);
    wr(8'h8d, 8'h00);
    cyc(2);
    wr(8'h88, 8'h00);
    rchk(8'h8b, 8'he1);
    rchk(8'h8d, 8'h01);
  endtask
  task automatic t_t2();
    int n;
    wr(8'hca, 8'hfc);
    wr(8'hcb, 8'hff);
    wr(8'hcc, 8'hfc);
    wr(8'hcd, 8'hff);
    wr(8'hc8, 8'h04);
    @(negedge clk);
    wchg(1, 40, n);
    wchg(1, 40, n);
    chk("wave2 gap", 8'h10, n[7:0]);
    chk("flag2", 8'h01, {7'h0, f2});
    wr(8'hc8, 8'h80);
    rchk(8'hcd, 8'hff);
    wr(8'hc8, 8'h00);
    @(negedge clk);
    chk("flag2 clr", 8'h00, {7'h0, f2});
  endtask
  task automatic t_baud();
    int rx0, tx0;
    wr(8'hcc, 8'hfc);
    wr(8'hcd, 8'hff);
    rx0 = u_pins.n_rx;
    tx0 = u_pins.n_tx;
    wr(8'hc8, 8'h35);
    cyc(78);
    wr(8'hc8, 8'h00);
    cyc(3);
    chk("rx t2", 8'h0a, 8'(u_pins.n_rx - rx0));
    chk("tx t2", 8'h0a, 8'(u_pins.n_tx - tx0));
    chk("flag2 baud", 8'h00, {7'h0, f2});
    wr(8'h89, 8'h20);
    wr(8'h8b, 8'hff);
    wr(8'h8d, 8'hff);
    rx0 = u_pins.n_rx;
    tx0 = u_pins.n_tx;
    wr(8'h88, 8'h40);
    cyc(2);
    @(negedge clk);
    chk("flag1", 8'h01, {7'h0, f1});
    wr(8'h88, 8'h80);
    cyc(3);
    chk("rx t1", 8'h02, 8'(u_pins.n_rx - rx0));
    chk("tx t1", 8'h02, 8'(u_pins.n_tx - tx0));
    ack1 <= 1'b1;
    @(posedge clk);
    ack1 <= 1'b0;
    @(negedge clk);
    chk("flag1 ack", 8'h00, {7'h0, f1});
  endtask
  task automatic t_cap();
    wr(8'hcc, 8'h34);
    wr(8'hcd, 8'h12);
    wr(8'hc8, 8'h09);
    u_pins.pulse(tmr_pkg::PIN_TRIG, 1);
    rchk(8'hca, 8'h34);
    rchk(8'hcb, 8'h12);
    chk("trig cap", 8'h01, {7'h0, fx});
    wr(8'hc8, 8'h08);
    wr(8'hcc, 8'h56);
    u_pins.pulse(tmr_pkg::PIN_TRIG, 1);
    rchk(8'hcc, 8'h34);
    chk("trig reload", 8'h01, {7'h0, fx});
    wr(8'hc8, 8'h00);
    wr(8'hcc, 8'h56);
    u_pins.pulse(tmr_pkg::PIN_TRIG, 1);
    rchk(8'hcc, 8'h56);
    chk("trig off", 8'h00, {7'h0, fx});
  endtask
  task automatic t_split();
    wr(8'h8a, 8'h00);
    wr(8'h8c, 8'hfe);
    wr(8'h89, 8'h33);
    wr(8'h88, 8'h40);
    cyc(4);
    @(negedge clk);
    chk("flag1 split", 8'h01, {7'h0, f1});
    wr(8'h88, 8'h00);
    rchk(8'h8c, 8'h01);
    rchk(8'h8a, 8'h00);
    rchk(8'h8b, 8'hff);
  endtask
  task automatic t_t2cnt();
    wr(8'hcc, 8'h00);
    wr(8'hcd, 8'h00);
    wr(8'hc8, 8'h06);
    u_pins.pulse(tmr_pkg::PIN_T2, 2);
    rchk(8'hcc, 8'h02);
    wr(8'hf8, 8'h04);
    u_pins.pulse(tmr_pkg::PIN_T2, 2);
    u_pins.pulse(tmr_pkg::PIN_SLOW, 16);
    rchk(8'hcc, 8'h03);
    wr(8'hc8, 8'h00);
    wr(8'hf8, 8'h00);
  endtask
  // ====================
  // main sequence
  initial
  begin
    n_fail = 0;
    tests_run = 0;
    arst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    ack0 = 1'b0;
    ack1 = 1'b0;
    cyc(12);
    arst_n <= 1'b1;
    t_regs();
    t_t0();
    t_gate();
    t_cnt();
    t_t2();
    t_baud();
    t_cap();
    t_split();
    t_t2cnt();
    end_sim();
  end
endmodule
`default_nettype wire

//--- tmr_pin_model.sv
// outside world of the timers: count, gate, trigger and slow clock pins, and a
// serial port counting baud ticks. assumes the timers' clock.
`default_nettype none
module tmr_pin_model (
  // clock
  input wire logic clk,
  // pins toward the timers
  output var tmr_pkg::tmr_pins_t pins,
  // baud ticks
  input wire logic rx_tick,
  input wire logic tx_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  int n_rx;
  int n_tx;
  initial
  begin
    pins = '1;
    n_rx = 0;
    n_tx = 0;
  end
  always @(posedge clk)
  begin
    n_rx <= n_rx + int'(rx_tick);
    n_tx <= n_tx + int'(tx_tick);
  end
  // falling edges, each level held three clocks
  task automatic pulse(input int lane, input int n);
    repeat (n)
    begin
      @(posedge clk);
      pins[lane] <= 1'b0;
      repeat (3) @(posedge clk);
      pins[lane] <= 1'b1;
      repeat (2) @(posedge clk);
    end
  endtask
  task automatic level(input int lane, input logic v);
    @(posedge clk);
    pins[lane] <= v;
  endtask
endmodule
`default_nettype wire

//--- tmr_pkg.sv
// constants, field positions and the state record of the three timer/counters.
// assumes one 100 MHz clock, an active-low asynchronous reset and a byte-wide
// special-function-register port with read data one cycle after the read strobe.
// Overview of operation
// - in timer mode every timer advances once per two system clocks
// - timer0 wave output toggles once per 64 timer0 overflows
// - timer2 wave output toggles once per 2 timer2 overflows
// - timer0/1 overflow flags set on overflow, cleared on vectoring acknowledge
// - timer0/1 count when run set and, if gated, its interrupt pin high
// - counter select makes timer0/1 count falling edges of their count input
// - mode 00: high byte counts behind a 5-bit low-byte prescaler
// - mode 01: high and low bytes form one 16-bit counter
// - mode 10: low byte counts, reloads from high byte on overflow
// - mode 11: timer1 halts; timer0 splits, high byte uses timer1 run and flag
// - timer2 overflow flag set on overflow unless a baud select; software clears
// - trigger flag set when a trigger edge causes capture or reload; software clears
// - each baud select picks timer2 overflow when set, timer1 overflow when clear
// - trigger edges act only when enabled and both baud selects clear
// - timer2 counter select: falling edges of selected input, else every two clocks
// - reload mode: timer2 reloads on overflow and on enabled trigger edges
// - capture mode: enabled trigger edge copies the count into the reload pair
// - any baud select forces auto-reload on overflow, ignoring capture select
// - timer2 counter source: count pin when clear, slow clock over 16 when set
// - timer1 counter source: count pin when clear, slow clock over 16 when set

`default_nettype none

package tmr_pkg;

  // =====================================================================
  // register offsets
  localparam logic [7:0] ADDR_T01_CTRL = 8'h88;
  localparam logic [7:0] ADDR_T01_MODE = 8'h89;
  localparam logic [7:0] ADDR_T0_LOW = 8'h8a;
  localparam logic [7:0] ADDR_T1_LOW = 8'h8b;
  localparam logic [7:0] ADDR_T0_HIGH = 8'h8c;
  localparam logic [7:0] ADDR_T1_HIGH = 8'h8d;
  localparam logic [7:0] ADDR_T2_CTRL = 8'hc8;
  localparam logic [7:0] ADDR_T2_RC_LOW = 8'hca;
  localparam logic [7:0] ADDR_T2_RC_HIGH = 8'hcb;
  localparam logic [7:0] ADDR_T2_LOW = 8'hcc;
  localparam logic [7:0] ADDR_T2_HIGH = 8'hcd;
  localparam logic [7:0] ADDR_AUX_ONE = 8'hf8;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // =====================================================================
  // field positions
  localparam int B_T1_FLAG = 7;
  localparam int B_T1_RUN = 6;
  localparam int B_T0_FLAG = 5;
  localparam int B_T0_RUN = 4;
  localparam int B_T1_GATE = 7;
  localparam int B_T1_CSEL = 6;
  localparam int B_T1_MODE = 4;
  localparam int B_T0_GATE = 3;
  localparam int B_T0_CSEL = 2;
  localparam int B_T0_MODE = 0;
  localparam int B_T2_FLAG = 7;
  localparam int B_T2_TRIG_FLAG = 6;
  localparam int B_RX_BAUD = 5;
  localparam int B_TX_BAUD = 4;
  localparam int B_T2_TRIG_EN = 3;
  localparam int B_T2_RUN = 2;
  localparam int B_T2_CSEL = 1;
  localparam int B_T2_CAPTURE = 0;
  localparam int B_T2_SRC = 2;
  localparam int B_T1_SRC = 1;

  // =====================================================================
  // modes and synchroniser lanes
  localparam logic [1:0] MODE_PRESCALE = 2'h0;
  localparam logic [1:0] MODE_WIDE = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;
  localparam int PIN_T0 = 0;
  localparam int PIN_T1 = 1;
  localparam int PIN_T2 = 2;
  localparam int PIN_TRIG = 3;
  localparam int PIN_SLOW = 4;
  localparam int PIN_EXT_IRQ_ZERO_PIN = 5;
  localparam int PIN_EXT_IRQ_ONE_PIN = 6;
  localparam int PIN_N = 7;

  // =====================================================================
  // timing counts
  localparam logic [4:0] PRESCALE_MAX = 5'h1f;
  localparam logic [3:0] SLOW_DIV_LAST = 4'hf;
  localparam logic [5:0] T0_WAVE_LAST = 6'h3f;
  localparam logic T2_WAVE_LAST = 1'b1;

  // =====================================================================
  // whole state of the block
  typedef struct packed {
    logic [7:0] t01_ctrl;
    logic [7:0] t01_mode;
    logic [7:0] t0_low;
    logic [7:0] t0_high;
    logic [7:0] t1_low;
    logic [7:0] t1_high;
    logic [7:0] t2_ctrl;
    logic [7:0] t2_rc_low;
    logic [7:0] t2_rc_high;
    logic [7:0] t2_low;
    logic [7:0] t2_high;
    logic timer2_count_source;
    logic timer1_count_source;
    logic base_phase;
    logic [PIN_N-1:0] pin_s1;
    logic [PIN_N-1:0] pin_s2;
    logic [PIN_N-1:0] pin_d;
    logic [3:0] slow_div;
    logic [5:0] t0_wave_cnt;
    logic timer0_wave_out;
    logic t2_wave_cnt;
    logic timer2_wave_out;
    logic rx_tick;
    logic tx_tick;
    logic [7:0] rdata;
  } tmr_state_t;

  // the external pins bundled as they arrive
  typedef struct packed {
    logic ext_irq_one_pin;
    logic ext_irq_zero_pin;
    logic low_speed_clock;
    logic timer2_trigger_input;
    logic t2_count_pin;
    logic t1_count_pin;
    logic t0_count_pin;
  } tmr_pins_t;

endpackage

`default_nettype wire

//--- tmr_timers.sv
// timer0, timer1 and timer2 with their register port, wave outputs and baud ticks.
// assumes pins are synchronous-looking levels sampled here, a vector acknowledge
// pulse from the interrupt controller, and a serial port that takes one-cycle ticks.

`default_nettype none

module tmr_timers (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // pins
  input wire tmr_pkg::tmr_pins_t pins,
  // interrupt controller
  input wire logic timer0_vector_ack,
  input wire logic timer1_vector_ack,
  output logic timer0_overflow_flag,
  output logic timer1_overflow_flag,
  output logic timer2_overflow_flag,
  output logic timer2_trigger_flag,
  // waveforms and serial clocks
  output logic timer0_wave_out,
  output logic timer2_wave_out,
  output logic serial_rx_baud_tick,
  output logic serial_tx_baud_tick
);

  // =====================================================================
  // state registers
  tmr_pkg::tmr_state_t s_ff;
  tmr_pkg::tmr_state_t nxt_s;

  // =====================================================================
  // one step of a timer0/1 style counter, result is {overflow, high, low}
  function automatic logic [16:0] step01(input logic [1:0] md, input logic [7:0] lo,
                                         input logic [7:0] hi, input logic en);
    logic [16:0] r;
    logic [16:0] wide;
    r = {1'b0, hi, lo};
    wide = {1'b0, hi, lo} + 17'h00001;
    if (en)
    begin
      case (md)
        tmr_pkg::MODE_PRESCALE:
        begin
          r[4:0] = lo[4:0] + 5'h01;
          if (lo[4:0] == tmr_pkg::PRESCALE_MAX)
          begin
            r[15:8] = hi + 8'h01;
            r[16] = (hi == 8'hff);
          end
        end
        tmr_pkg::MODE_WIDE:
        begin
          r = wide;
        end
        tmr_pkg::MODE_RELOAD:
        begin
          r[7:0] = (lo == 8'hff) ? hi : lo + 8'h01;
          r[16] = (lo == 8'hff);
        end
        default:
        begin
          r[7:0] = lo + 8'h01;
          r[16] = (lo == 8'hff);
        end
      endcase
    end
    return r;
  endfunction

  // =====================================================================
  // combinational next state
  always_comb
  begin
    logic base_tick;
    logic [tmr_pkg::PIN_N-1:0] fall;
    logic slow_tick;
    logic [1:0] md0;
    logic [1:0] md1;
    logic split;
    logic en0;
    logic en1;
    logic en0_high;
    logic inc0;
    logic inc1;
    logic inc2;
    logic [16:0] r0;
    logic [16:0] r1;
    logic [7:0] th0_split;
    logic th0_ovf;
    logic t0_ovf;
    logic t1_ovf;
    logic baud_mode;
    logic trig;
    logic [16:0] cnt2;
    logic t2_ovf;
    logic [7:0] rd;
    base_tick = 1'b0;
    fall = '0;
    slow_tick = 1'b0;
    md0 = 2'h0;
    md1 = 2'h0;
    split = 1'b0;
    en0 = 1'b0;
    en1 = 1'b0;
    en0_high = 1'b0;
    inc0 = 1'b0;
    inc1 = 1'b0;
    inc2 = 1'b0;
    r0 = '0;
    r1 = '0;
    th0_split = 8'h00;
    th0_ovf = 1'b0;
    t0_ovf = 1'b0;
    t1_ovf = 1'b0;
    baud_mode = 1'b0;
    trig = 1'b0;
    cnt2 = '0;
    t2_ovf = 1'b0;
    rd = 8'h00;
    nxt_s = s_ff;

    // input synchronisers and falling-edge detection
    nxt_s.pin_s1 = pins;
    nxt_s.pin_s2 = s_ff.pin_s1;
    nxt_s.pin_d = s_ff.pin_s2;
    fall = s_ff.pin_d & ~s_ff.pin_s2;

    // two-clock time base
    nxt_s.base_phase = ~s_ff.base_phase;
    base_tick = s_ff.base_phase;

    // slow clock divided by sixteen
    if (fall[tmr_pkg::PIN_SLOW])
    begin
      nxt_s.slow_div = s_ff.slow_div + 4'h1;
      slow_tick = (s_ff.slow_div == tmr_pkg::SLOW_DIV_LAST);
    end

    // =====================================================================
    // timer0 and timer1
    md0 = s_ff.t01_mode[tmr_pkg::B_T0_MODE +: 2];
    md1 = s_ff.t01_mode[tmr_pkg::B_T1_MODE +: 2];
    split = (md0 == tmr_pkg::MODE_SPLIT);
    en0 = s_ff.t01_ctrl[tmr_pkg::B_T0_RUN] &
          (~s_ff.t01_mode[tmr_pkg::B_T0_GATE] | s_ff.pin_s2[tmr_pkg::PIN_EXT_IRQ_ZERO_PIN]);
    en1 = s_ff.t01_ctrl[tmr_pkg::B_T1_RUN] &
          (~s_ff.t01_mode[tmr_pkg::B_T1_GATE] | s_ff.pin_s2[tmr_pkg::PIN_EXT_IRQ_ONE_PIN]);
    inc0 = en0 & (s_ff.t01_mode[tmr_pkg::B_T0_CSEL] ? fall[tmr_pkg::PIN_T0]
                                                    : base_tick);
    inc1 = en1 & (md1 != tmr_pkg::MODE_SPLIT) &
           (s_ff.t01_mode[tmr_pkg::B_T1_CSEL] ?
            (s_ff.timer1_count_source ? slow_tick : fall[tmr_pkg::PIN_T1])
            : base_tick);
    r0 = step01(md0, s_ff.t0_low, s_ff.t0_high, inc0);
    r1 = step01(md1, s_ff.t1_low, s_ff.t1_high, inc1);
    t0_ovf = r0[16];
    t1_ovf = r1[16];

    // split mode: high byte of timer0 runs on timer1's run bit
    en0_high = split & s_ff.t01_ctrl[tmr_pkg::B_T1_RUN] & base_tick;
    th0_split = en0_high ? s_ff.t0_high + 8'h01 : s_ff.t0_high;
    th0_ovf = en0_high & (s_ff.t0_high == 8'hff);

    nxt_s.t0_low = r0[7:0];
    nxt_s.t0_high = split ? th0_split : r0[15:8];
    nxt_s.t1_low = r1[7:0];
    nxt_s.t1_high = r1[15:8];

    // flags: vector acknowledge clears, software writes, hardware set wins
    if (timer0_vector_ack)
    begin
      nxt_s.t01_ctrl[tmr_pkg::B_T0_FLAG] = 1'b0;
    end
    if (timer1_vector_ack)
    begin
      nxt_s.t01_ctrl[tmr_pkg::B_T1_FLAG] = 1'b0;
    end
    if (reg_wr && reg_addr == tmr_pkg::ADDR_T01_CTRL)
    begin
      nxt_s.t01_ctrl = reg_wdata;
    end
    if (t0_ovf)
    begin
      nxt_s.t01_ctrl[tmr_pkg::B_T0_FLAG] = 1'b1;
    end
    if (split ? th0_ovf : t1_ovf)
    begin
      nxt_s.t01_ctrl[tmr_pkg::B_T1_FLAG] = 1'b1;
    end

    // =====================================================================
    // timer2
    baud_mode = s_ff.t2_ctrl[tmr_pkg::B_RX_BAUD] | s_ff.t2_ctrl[tmr_pkg::B_TX_BAUD];
    inc2 = s_ff.t2_ctrl[tmr_pkg::B_T2_RUN] &
           (s_ff.t2_ctrl[tmr_pkg::B_T2_CSEL] ?
            (s_ff.timer2_count_source ? slow_tick : fall[tmr_pkg::PIN_T2])
            : base_tick);
    trig = fall[tmr_pkg::PIN_TRIG] & s_ff.t2_ctrl[tmr_pkg::B_T2_TRIG_EN] & ~baud_mode;
    cnt2 = {1'b0, s_ff.t2_high, s_ff.t2_low} + {16'h0000, inc2};
    t2_ovf = cnt2[16];
    nxt_s.t2_low = cnt2[7:0];
    nxt_s.t2_high = cnt2[15:8];
    if (t2_ovf && (baud_mode || !s_ff.t2_ctrl[tmr_pkg::B_T2_CAPTURE]))
    begin
      nxt_s.t2_low = s_ff.t2_rc_low;
      nxt_s.t2_high = s_ff.t2_rc_high;
    end
    if (trig && !s_ff.t2_ctrl[tmr_pkg::B_T2_CAPTURE])
    begin
      nxt_s.t2_low = s_ff.t2_rc_low;
      nxt_s.t2_high = s_ff.t2_rc_high;
    end
    if (trig && s_ff.t2_ctrl[tmr_pkg::B_T2_CAPTURE])
    begin
      nxt_s.t2_rc_low = s_ff.t2_low;
      nxt_s.t2_rc_high = s_ff.t2_high;
    end
    if (reg_wr && reg_addr == tmr_pkg::ADDR_T2_CTRL)
    begin
      nxt_s.t2_ctrl = reg_wdata;
    end
    if (t2_ovf && !baud_mode)
    begin
      nxt_s.t2_ctrl[tmr_pkg::B_T2_FLAG] = 1'b1;
    end
    if (trig)
    begin
      nxt_s.t2_ctrl[tmr_pkg::B_T2_TRIG_FLAG] = 1'b1;
    end

    // =====================================================================
    // wave outputs and baud ticks
    if (t0_ovf)
    begin
      nxt_s.t0_wave_cnt = s_ff.t0_wave_cnt + 6'h01;
      if (s_ff.t0_wave_cnt == tmr_pkg::T0_WAVE_LAST)
      begin
        nxt_s.timer0_wave_out = ~s_ff.timer0_wave_out;
      end
    end
    if (t2_ovf)
    begin
      nxt_s.t2_wave_cnt = ~s_ff.t2_wave_cnt;
      if (s_ff.t2_wave_cnt == tmr_pkg::T2_WAVE_LAST)
      begin
        nxt_s.timer2_wave_out = ~s_ff.timer2_wave_out;
      end
    end
    nxt_s.rx_tick = s_ff.t2_ctrl[tmr_pkg::B_RX_BAUD] ? t2_ovf : t1_ovf;
    nxt_s.tx_tick = s_ff.t2_ctrl[tmr_pkg::B_TX_BAUD] ? t2_ovf : t1_ovf;

    // =====================================================================
    // software writes to data registers override counting
    if (reg_wr)
    begin
      case (reg_addr)
        tmr_pkg::ADDR_T01_MODE: nxt_s.t01_mode = reg_wdata;
        tmr_pkg::ADDR_T0_LOW: nxt_s.t0_low = reg_wdata;
        tmr_pkg::ADDR_T1_LOW: nxt_s.t1_low = reg_wdata;
        tmr_pkg::ADDR_T0_HIGH: nxt_s.t0_high = reg_wdata;
        tmr_pkg::ADDR_T1_HIGH: nxt_s.t1_high = reg_wdata;
        tmr_pkg::ADDR_T2_RC_LOW: nxt_s.t2_rc_low = reg_wdata;
        tmr_pkg::ADDR_T2_RC_HIGH: nxt_s.t2_rc_high = reg_wdata;
        tmr_pkg::ADDR_T2_LOW: nxt_s.t2_low = reg_wdata;
        tmr_pkg::ADDR_T2_HIGH: nxt_s.t2_high = reg_wdata;
        tmr_pkg::ADDR_AUX_ONE:
        begin
          nxt_s.timer2_count_source = reg_wdata[tmr_pkg::B_T2_SRC];
          nxt_s.timer1_count_source = reg_wdata[tmr_pkg::B_T1_SRC];
        end
        default:
        begin
          nxt_s.t01_mode = nxt_s.t01_mode;
        end
      endcase
    end

    // =====================================================================
    // read port, data one cycle after the strobe
    case (reg_addr)
      tmr_pkg::ADDR_T01_CTRL: rd = s_ff.t01_ctrl;
      tmr_pkg::ADDR_T01_MODE: rd = s_ff.t01_mode;
      tmr_pkg::ADDR_T0_LOW: rd = s_ff.t0_low;
      tmr_pkg::ADDR_T1_LOW: rd = s_ff.t1_low;
      tmr_pkg::ADDR_T0_HIGH: rd = s_ff.t0_high;
      tmr_pkg::ADDR_T1_HIGH: rd = s_ff.t1_high;
      tmr_pkg::ADDR_T2_CTRL: rd = s_ff.t2_ctrl;
      tmr_pkg::ADDR_T2_RC_LOW: rd = s_ff.t2_rc_low;
      tmr_pkg::ADDR_T2_RC_HIGH: rd = s_ff.t2_rc_high;
      tmr_pkg::ADDR_T2_LOW: rd = s_ff.t2_low;
      tmr_pkg::ADDR_T2_HIGH: rd = s_ff.t2_high;
      tmr_pkg::ADDR_AUX_ONE:
      begin
        rd[tmr_pkg::B_T2_SRC] = s_ff.timer2_count_source;
        rd[tmr_pkg::B_T1_SRC] = s_ff.timer1_count_source;
      end
      default: rd = 8'h00;
    endcase
    nxt_s.rdata = reg_rd ? rd : 8'h00;
  end

  // =====================================================================
  // state register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_ff <= '0;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  // =====================================================================
  // outputs
  assign reg_rdata = s_ff.rdata;
  assign timer0_overflow_flag = s_ff.t01_ctrl[tmr_pkg::B_T0_FLAG];
  assign timer1_overflow_flag = s_ff.t01_ctrl[tmr_pkg::B_T1_FLAG];
  assign timer2_overflow_flag = s_ff.t2_ctrl[tmr_pkg::B_T2_FLAG];
  assign timer2_trigger_flag = s_ff.t2_ctrl[tmr_pkg::B_T2_TRIG_FLAG];
  assign timer0_wave_out = s_ff.timer0_wave_out;
  assign timer2_wave_out = s_ff.timer2_wave_out;
  assign serial_rx_baud_tick = s_ff.rx_tick;
  assign serial_tx_baud_tick = s_ff.tx_tick;

endmodule

`default_nettype wire

//--- tmr_timers_props.sv
// checker for the timer block: read port, flag clearing, wave spacing, baud ticks.
// assumes it is bound to tmr_timers and sees only that module's ports.
`default_nettype none
module tmr_timers_props (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // flags, waves and ticks
  input wire logic timer0_vector_ack,
  input wire logic timer1_vector_ack,
  input wire logic timer0_overflow_flag,
  input wire logic timer1_overflow_flag,
  input wire logic timer2_overflow_flag,
  input wire logic timer2_trigger_flag,
  input wire logic timer0_wave_out,
  input wire logic serial_rx_baud_tick,
  input wire logic serial_tx_baud_tick
);
  // ====================
  // helper logic
  logic unmapped;
  logic wr_t01;
  logic wr_t2;
  logic [3:0] clr_ff;
  logic [7:0] gap_ff;
  assign unmapped = !(reg_addr inside {[8'h88:8'h8d], 8'hc8, [8'hca:8'hcd], 8'hf8});
  assign wr_t01 = reg_wr && reg_addr == tmr_pkg::ADDR_T01_CTRL;
  assign wr_t2 = reg_wr && reg_addr == tmr_pkg::ADDR_T2_CTRL;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      clr_ff <= 4'h0;
      gap_ff <= 8'h00;
    end
    else
    begin
      clr_ff <= {wr_t2 && !reg_wdata[6], wr_t2 && !reg_wdata[7],
                 timer1_vector_ack || (wr_t01 && !reg_wdata[7]),
                 timer0_vector_ack || (wr_t01 && !reg_wdata[5])};
      if ($changed(timer0_wave_out))
        gap_ff <= 8'h00;
      else if (gap_ff != 8'hff)
        gap_ff <= gap_ff + 8'h01;
    end
  end
  // ====================
  // properties
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  AST_RD_IDLE:
    assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("rdata not idle");
  AST_UNMAPPED:
    assert property (reg_rd && unmapped |=> reg_rdata == 8'h00) else $error("unmapped read");
  AST_AUX_BITS:
    assert property (reg_rd && reg_addr == 8'hf8 |=> (reg_rdata & 8'hf9) == 8'h00)
    else $error("aux spare bits");
  AST_T0_CLR:
    assert property ($fell(timer0_overflow_flag) |-> clr_ff[0]) else $error("flag0 fell");
  AST_T1_CLR:
    assert property ($fell(timer1_overflow_flag) |-> clr_ff[1]) else $error("flag1 fell");
  AST_T2_CLR:
    assert property ($fell(timer2_overflow_flag) |-> clr_ff[2]) else $error("flag2 fell");
  AST_TRIG_CLR:
    assert property ($fell(timer2_trigger_flag) |-> clr_ff[3]) else $error("trig flag fell");
  AST_RX_GAP:
    assert property (serial_rx_baud_tick |=> !serial_rx_baud_tick) else $error("rx tick gap");
  AST_TX_GAP:
    assert property (serial_tx_baud_tick |=> !serial_tx_baud_tick) else $error("tx tick gap");
  AST_T0_WAVE:
    assert property ($changed(timer0_wave_out) |-> gap_ff >= 8'h7f) else $error("wave0 fast");
  COV_TRIG: cover property ($rose(timer2_trigger_flag));
  COV_WAVE: cover property ($changed(timer0_wave_out));
  COV_TICK: cover property (serial_tx_baud_tick);
endmodule
bind tmr_timers tmr_timers_props u_props (.clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .timer0_vector_ack, .timer1_vector_ack, .timer0_overflow_flag,
  .timer1_overflow_flag, .timer2_overflow_flag, .timer2_trigger_flag, .timer0_wave_out,
  .serial_rx_baud_tick, .serial_tx_baud_tick);
`default_nettype wire
